// >>> src/port_mux_pkg.sv
// constants, field layouts and carrier types for the port A pin priority multiplexer
// assumes a 32-bit AXI4-Lite register bus and a single system clock
package port_mux_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int PORT_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_ANALOG_SELECT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SLEW_RATE     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DIRECTION     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_OSC_CONFIG    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PIN_STATUS    = 8'h14;

  // implemented bits, all others read as zero
  localparam logic [PORT_W-1:0] ANALOG_MASK = 8'h2F;
  localparam logic [PORT_W-1:0] SLEW_MASK   = 8'h1F;
  localparam logic [PORT_W-1:0] OSC_MASK    = 8'h1F;

  // reset values
  localparam logic [PORT_W-1:0] ANALOG_RST = 8'h2F;
  localparam logic [PORT_W-1:0] LATCH_RST  = 8'h00;
  localparam logic [PORT_W-1:0] SLEW_RST   = 8'h1F;
  localparam logic [PORT_W-1:0] DIR_RST    = 8'hFF;
  localparam logic [PORT_W-1:0] OSC_RST    = 8'h18;

  // oscillator configuration fields
  localparam int OSC_MODE_LSB     = 0;
  localparam int OSC_MODE_W       = 2;
  localparam int OSC_CLKOUT_BIT   = 2;
  localparam int OSC_PKG28_BIT    = 3;
  localparam int OSC_CAPTURE_COMPARE_FIVE_DEF_BIT = 4;

  // pin positions with special functions
  localparam int BIT_SR_COMP1 = 4;
  localparam int BIT_SR_COMP2 = 5;
  localparam int BIT_OSC_OUT  = 6;
  localparam int BIT_OSC_IN   = 7;

  // instruction clock: toggle every two system cycles gives one quarter rate
  localparam int CLKOUT_HALF_PERIOD = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [OSC_MODE_W-1:0] {
    OSC_INTERNAL,
    OSC_RC,
    OSC_CRYSTAL,
    OSC_EXT_CLOCK
  } osc_mode_t;

  // competing peripheral outputs, each with its own enable
  typedef struct packed {
    logic latch_set_output_en;
    logic latch_set_output;
    logic latch_inverse_output_en;
    logic latch_inverse_output;
    logic comparator_one_output_en;
    logic comparator_one_output;
    logic comparator_two_output_en;
    logic comparator_two_output;
    logic capture_compare_five_en;
    logic capture_compare_five;
  } periph_t;

  // winner of one pin's priority list
  typedef struct packed {
    logic drive;
    logic value;
  } pin_drive_t;

endpackage : port_mux_pkg

// >>> src/pin_priority_cell.sv
// one pin's output priority selector, entry 0 ranks highest
// assumes requests come from logic on the same clock; purely combinational
`timescale 1ns/10ps
module pin_priority_cell #(
  parameter int N = 4
) (
  input  wire logic [N-1:0]            i_en,
  input  wire logic [N-1:0]            i_val,
  output port_mux_pkg::pin_drive_t     o_drive
);

  function automatic port_mux_pkg::pin_drive_t pick(input logic [N-1:0] en,
                                                     input logic [N-1:0] val);
    port_mux_pkg::pin_drive_t r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (en[k]) begin
        r.drive = 1'b1;
        r.value = val[k];
      end
    end
    return r;
  endfunction : pick

  always_comb begin
    o_drive = pick(i_en, i_val);
  end

endmodule : pin_priority_cell

// >>> src/port_a_pin_function_priority_mux.sv
// port A pin function priority multiplexer with AXI4-Lite register access
// assumes peripheral outputs arrive on the system clock; pin inputs are asynchronous
//
// Notes on behaviour
// - highest ranked enabled function owns the pin
// - port A pin ranking fixed per bit
// - peripherals outrank latch
// - variant and relocation fuse shape lists
// - analog inputs live only in analog mode
// - digital outputs still win in analog mode
// - pin 6 latch output only internal, no clockout
// - pin 6 input only internal, no clockout
// - rc mode drives quarter rate clock on 6
// - external oscillator modes disable pin 7 output
// - external oscillator modes disable pin 7 input
// - crystal mode pin 6 drives resonator
// - unimplemented register bits read zero
// - direction 1 input, 0 drives latch
// - pin 4 digital input after reset
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module port_a_pin_function_priority_mux #(
  parameter int PORT_W = port_mux_pkg::PORT_W
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_rst,
  // AXI4-Lite slave
  input  wire logic [port_mux_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [port_mux_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [port_mux_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [port_mux_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // competing peripherals
  input  wire port_mux_pkg::periph_t             i_periph,
  // pins
  input  wire logic [PORT_W-1:0]                 i_pin_in,
  output logic [PORT_W-1:0]                      o_pin_out,
  output logic [PORT_W-1:0]                      o_pin_oe_n,
  output logic [PORT_W-1:0]                      o_analog_en,
  output logic [PORT_W-1:0]                      o_digital_in,
  output logic                                   o_instruction_clock_out
);

  // ---------------- registers ----------------
  logic [PORT_W-1:0] analog_select_reg;
  logic [PORT_W-1:0] output_latch_reg;
  logic [PORT_W-1:0] slew_reg;
  logic [PORT_W-1:0] direction_reg;
  logic [PORT_W-1:0] osc_cfg_reg;

  // ---------------- pin synchroniser ----------------
  logic [PORT_W-1:0] pin_meta_reg;
  logic [PORT_W-1:0] pin_sync_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= i_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------- oscillator decode ----------------
  port_mux_pkg::osc_mode_t osc_mode;
  logic                    clkout_en;
  logic                    pkg_28pin;
  logic                    capture_compare_five_default_pin;
  logic                    osc_internal;
  logic                    osc_external;

  always_comb begin
    osc_mode = port_mux_pkg::osc_mode_t'(
      osc_cfg_reg[port_mux_pkg::OSC_MODE_LSB +: port_mux_pkg::OSC_MODE_W]);
    clkout_en        = osc_cfg_reg[port_mux_pkg::OSC_CLKOUT_BIT];
    pkg_28pin        = osc_cfg_reg[port_mux_pkg::OSC_PKG28_BIT];
    capture_compare_five_default_pin = osc_cfg_reg[port_mux_pkg::OSC_CAPTURE_COMPARE_FIVE_DEF_BIT];
    osc_internal     = (osc_mode == port_mux_pkg::OSC_INTERNAL);
    osc_external     = !osc_internal;
  end

  // instruction clock at one quarter of the oscillator rate
  logic [1:0] clkdiv_reg;
  logic       iclk_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      clkdiv_reg <= '0;
      iclk_reg   <= 1'b0;
    end else if (clkdiv_reg == 2'(port_mux_pkg::CLKOUT_HALF_PERIOD - 1)) begin
      clkdiv_reg <= '0;
      iclk_reg   <= !iclk_reg;
    end else begin
      clkdiv_reg <= clkdiv_reg + 2'h1;
    end
  end

  // ---------------- priority lists ----------------
  port_mux_pkg::pin_drive_t drive [PORT_W];
  logic capture_compare_five_on_pin4;
  logic pin6_latch_ok;
  logic pin7_latch_ok;
  logic osc_out_clock;
  logic osc_out_crystal;

  always_comb begin
    capture_compare_five_on_pin4    = pkg_28pin && capture_compare_five_default_pin;
    pin6_latch_ok   = osc_internal && !clkout_en;
    pin7_latch_ok   = osc_internal;
    osc_out_clock   = (osc_mode == port_mux_pkg::OSC_RC) || (osc_internal && clkout_en);
    osc_out_crystal = (osc_mode == port_mux_pkg::OSC_CRYSTAL);
  end

  // bits 0 to 3 carry only the latch; peripherals never outrank them here
  for (genvar b = 0; b < port_mux_pkg::BIT_SR_COMP1; b++) begin : g_plain
    pin_priority_cell #(.N(1)) u_cell (
      .i_en    (!direction_reg[b]),
      .i_val   (output_latch_reg[b]),
      .o_drive (drive[b])
    );
  end

  // bit 4: set output, comparator one, capture/compare five, latch
  pin_priority_cell #(.N(4)) u_cell4 (
    .i_en    ({!direction_reg[port_mux_pkg::BIT_SR_COMP1],
               i_periph.capture_compare_five_en && capture_compare_five_on_pin4,
               i_periph.comparator_one_output_en,
               i_periph.latch_set_output_en}),
    .i_val   ({output_latch_reg[port_mux_pkg::BIT_SR_COMP1],
               i_periph.capture_compare_five,
               i_periph.comparator_one_output,
               i_periph.latch_set_output}),
    .o_drive (drive[port_mux_pkg::BIT_SR_COMP1])
  );

  // bit 5: inverse output, comparator two, latch
  pin_priority_cell #(.N(3)) u_cell5 (
    .i_en    ({!direction_reg[port_mux_pkg::BIT_SR_COMP2],
               i_periph.comparator_two_output_en,
               i_periph.latch_inverse_output_en}),
    .i_val   ({output_latch_reg[port_mux_pkg::BIT_SR_COMP2],
               i_periph.comparator_two_output,
               i_periph.latch_inverse_output}),
    .o_drive (drive[port_mux_pkg::BIT_SR_COMP2])
  );

  // bit 6: crystal output, clock out, latch
  pin_priority_cell #(.N(3)) u_cell6 (
    .i_en    ({!direction_reg[port_mux_pkg::BIT_OSC_OUT] && pin6_latch_ok,
               osc_out_clock,
               osc_out_crystal}),
    .i_val   ({output_latch_reg[port_mux_pkg::BIT_OSC_OUT],
               iclk_reg,
               !pin_sync_reg[port_mux_pkg::BIT_OSC_IN]}),
    .o_drive (drive[port_mux_pkg::BIT_OSC_OUT])
  );

  // bit 7: latch only, and only while the oscillator is internal
  pin_priority_cell #(.N(1)) u_cell7 (
    .i_en    (!direction_reg[port_mux_pkg::BIT_OSC_IN] && pin7_latch_ok),
    .i_val   (output_latch_reg[port_mux_pkg::BIT_OSC_IN]),
    .o_drive (drive[port_mux_pkg::BIT_OSC_IN])
  );

  // ---------------- pin outputs ----------------
  logic [PORT_W-1:0] drive_en;
  logic [PORT_W-1:0] drive_val;
  logic [PORT_W-1:0] dig_in_en;

  always_comb begin
    for (int b = 0; b < PORT_W; b++) begin
      drive_en[b]  = drive[b].drive;
      drive_val[b] = drive[b].value;
    end
    // digital input buffer off for analog pins and oscillator-owned pins
    dig_in_en = ~(analog_select_reg & port_mux_pkg::ANALOG_MASK);
    dig_in_en[port_mux_pkg::BIT_OSC_OUT] = pin6_latch_ok;
    dig_in_en[port_mux_pkg::BIT_OSC_IN]  = !osc_external;
  end

  // winner's value and enable register together so they reach the pin on one edge
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pin_out  <= '0;
      o_pin_oe_n <= '1;
    end else begin
      o_pin_out  <= drive_val;
      o_pin_oe_n <= ~drive_en;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_analog_en  <= port_mux_pkg::ANALOG_RST & port_mux_pkg::ANALOG_MASK;
      o_digital_in <= '0;
    end else begin
      o_analog_en  <= analog_select_reg & port_mux_pkg::ANALOG_MASK;
      o_digital_in <= pin_sync_reg & dig_in_en;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_instruction_clock_out <= 1'b0;
    end else begin
      o_instruction_clock_out <= iclk_reg;
    end
  end

  // ---------------- AXI4-Lite write path ----------------
  logic                              aw_held_reg;
  logic [port_mux_pkg::ADDR_W-1:0]   aw_addr_reg;
  logic                              w_held_reg;
  logic [port_mux_pkg::DATA_W-1:0]   w_data_reg;
  logic                              w_lane0_reg;
  logic                              do_write;
  logic                              wr_hit;
  logic                              aw_held_next;
  logic                              w_held_next;
  logic                              bvalid_next;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg  <= 1'b1;
      w_data_reg  <= s_axi_wdata;
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    do_write     = aw_held_reg && w_held_reg && !s_axi_bvalid;
    aw_held_next = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) && !do_write;
    w_held_next  = (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !do_write;
    bvalid_next  = do_write || (s_axi_bvalid && !s_axi_bready);
  end

  // ready flags are flops that track the next channel state, so the ports stay registered
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready  <= !w_held_next && !bvalid_next;
    end
  end

  function automatic logic addr_known(input logic [port_mux_pkg::ADDR_W-1:0] a);
    return a == port_mux_pkg::OFF_ANALOG_SELECT || a == port_mux_pkg::OFF_PIN_LEVEL
        || a == port_mux_pkg::OFF_SLEW_RATE || a == port_mux_pkg::OFF_DIRECTION
        || a == port_mux_pkg::OFF_OSC_CONFIG || a == port_mux_pkg::OFF_PIN_STATUS;
  endfunction : addr_known

  always_comb begin
    wr_hit = addr_known(aw_addr_reg) && (aw_addr_reg != port_mux_pkg::OFF_PIN_STATUS);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= port_mux_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? port_mux_pkg::RESP_OKAY : port_mux_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register file; only byte lane 0 holds data
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      analog_select_reg <= port_mux_pkg::ANALOG_RST;
      output_latch_reg  <= port_mux_pkg::LATCH_RST;
      slew_reg          <= port_mux_pkg::SLEW_RST;
      direction_reg     <= port_mux_pkg::DIR_RST;
      osc_cfg_reg       <= port_mux_pkg::OSC_RST;
    end else if (do_write && w_lane0_reg) begin
      unique case (aw_addr_reg)
        port_mux_pkg::OFF_ANALOG_SELECT: begin
          analog_select_reg <= w_data_reg[PORT_W-1:0] & port_mux_pkg::ANALOG_MASK;
        end
        port_mux_pkg::OFF_PIN_LEVEL: begin
          output_latch_reg <= w_data_reg[PORT_W-1:0];
        end
        port_mux_pkg::OFF_SLEW_RATE: begin
          slew_reg <= w_data_reg[PORT_W-1:0] & port_mux_pkg::SLEW_MASK;
        end
        port_mux_pkg::OFF_DIRECTION: begin
          direction_reg <= w_data_reg[PORT_W-1:0];
        end
        port_mux_pkg::OFF_OSC_CONFIG: begin
          osc_cfg_reg <= w_data_reg[PORT_W-1:0] & port_mux_pkg::OSC_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  logic [PORT_W-1:0] rd_byte;

  always_comb begin
    rd_byte = '0;
    unique case (s_axi_araddr)
      port_mux_pkg::OFF_ANALOG_SELECT: rd_byte = analog_select_reg & port_mux_pkg::ANALOG_MASK;
      port_mux_pkg::OFF_PIN_LEVEL:     rd_byte = pin_sync_reg & dig_in_en;
      port_mux_pkg::OFF_SLEW_RATE:     rd_byte = slew_reg & port_mux_pkg::SLEW_MASK;
      port_mux_pkg::OFF_DIRECTION:     rd_byte = direction_reg;
      port_mux_pkg::OFF_OSC_CONFIG:    rd_byte = osc_cfg_reg & port_mux_pkg::OSC_MASK;
      port_mux_pkg::OFF_PIN_STATUS:    rd_byte = ~o_pin_oe_n;
      default:                         rd_byte = '0;
    endcase
  end

  // arready is kept as the inverse of rvalid in a flop of its own
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= port_mux_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {{(port_mux_pkg::DATA_W - PORT_W){1'b0}}, rd_byte};
      s_axi_rresp  <= addr_known(s_axi_araddr) ? port_mux_pkg::RESP_OKAY
                                               : port_mux_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule : port_a_pin_function_priority_mux

// >>> testbench/port_mux_asserts.sv
// checker for the port A multiplexer: bus handshake, reset state and clock out
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module port_mux_checker #(
  parameter int PORT_W = 8
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [PORT_W-1:0] o_pin_out,
  input wire logic [PORT_W-1:0] o_pin_oe_n,
  input wire logic [PORT_W-1:0] o_analog_en,
  input wire logic              o_instruction_clock_out
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during read data");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without address");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  analog_mask_a: assert property ((o_analog_en & 8'hD0) == 8'h00)
    else $error("analog enable on unimplemented bit");
  reset_idle_a: assert property ($fell(i_rst) |-> o_pin_oe_n == 8'hFF && o_pin_out == 8'h00)
    else $error("pins not idle after reset");
  clk_high_a: assert property ($rose(o_instruction_clock_out) |=>
    o_instruction_clock_out ##1 !o_instruction_clock_out) else $error("clock out high phase");
  clk_low_a: assert property ($fell(o_instruction_clock_out) |=>
    !o_instruction_clock_out ##1 o_instruction_clock_out) else $error("clock out low phase");
endmodule : port_mux_checker

bind port_a_pin_function_priority_mux port_mux_checker #(.PORT_W(PORT_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
  .o_analog_en(o_analog_en), .o_instruction_clock_out(o_instruction_clock_out));

// >>> testbench/periph_model.sv
// competing peripheral outputs presented to the pin multiplexer
// assumes commands from the bench on the system clock
`timescale 1ns/10ps
module periph_model (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire port_mux_pkg::periph_t i_cmd,
  output port_mux_pkg::periph_t      o_periph
);
  // set/reset latch outputs stay complementary whatever is asked
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_periph <= '0;
    end else begin
      o_periph <= i_cmd;
      o_periph.latch_inverse_output <= ~i_cmd.latch_set_output;
    end
  end
endmodule : periph_model

// >>> testbench/testbench.sv
// self-checking bench for the port A pin priority multiplexer
// assumes the package constants and a 10 MHz clock
`timescale 1ns/10ps
module testbench;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, clk_out;
  logic [7:0] awaddr, araddr, pin_in, pin_out, oe_n, ana_en, dig_in;
  logic [7:0] dir_m, lat_m, ana_m, osc_m, din_x;
  logic [31:0] wdata, rdata, rnd;
  logic [23:0] e;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  port_mux_pkg::periph_t cmd, periph;
  int mismatches, n_compared, seed;

  port_a_pin_function_priority_mux dut (.i_sys_clk(clk), .i_rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_periph(periph), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(oe_n),
    .o_analog_en(ana_en), .o_digital_in(dig_in), .o_instruction_clock_out(clk_out));
  periph_model u_periph (.i_sys_clk(clk), .i_rst(rst), .i_cmd(cmd), .o_periph(periph));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if (((got ^ exp) & m) !== 32'h0) begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    tb = 1'b0;
    while (!tb && n < 40) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (n == 2) bready <= 1'b1;
      n++;
    end
    bready <= 1'b0;
    if (!tb) begin
      mismatches++;
      complete_run();
    end
    check(r, er, 32'h3);
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    tr = 1'b0;
    while (!tr && n < 40) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (n == 2) rready <= 1'b1;
      n++;
    end
    rready <= 1'b0;
    if (!tr) begin
      mismatches++;
      complete_run();
    end
    check(d, x, 32'hFFFFFFFF);
    check(r, er, 32'h3);
    @(posedge clk);
  endtask : axi_read

  // returns compare mask, expected active low enable and expected value
  function automatic logic [23:0] expect_pins(input port_mux_pkg::periph_t p);
    logic [7:0] drv, val, msk;
    drv = ~dir_m;
    val = lat_m;
    msk = 8'hFF;
    if (p.latch_set_output_en) {drv[4], val[4]} = {1'b1, p.latch_set_output};
    else if (p.comparator_one_output_en) {drv[4], val[4]} = {1'b1, p.comparator_one_output};
    else if (p.capture_compare_five_en && osc_m[3] && osc_m[4])
      {drv[4], val[4]} = {1'b1, p.capture_compare_five};
    if (p.latch_inverse_output_en) {drv[5], val[5]} = {1'b1, p.latch_inverse_output};
    else if (p.comparator_two_output_en) {drv[5], val[5]} = {1'b1, p.comparator_two_output};
    // pin 6 carries a clock in these modes, so only its enable is compared
    if (osc_m[1:0] == 2'h2 || osc_m[1:0] == 2'h1 || (osc_m[1:0] == 2'h0 && osc_m[2]))
      {drv[6], msk[6]} = 2'b10;
    else if (osc_m[1:0] != 2'h0) drv[6] = 1'b0;
    if (osc_m[1:0] != 2'h0) drv[7] = 1'b0;
    return {msk & drv, ~drv, val};
  endfunction : expect_pins

  initial begin
    seed = 32'h34e09e99;
    mismatches = 0;
    n_compared = 0;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, pin_in} = '0;
    cmd = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(oe_n, 8'hFF, 8'hFF);
    check(ana_en, 8'h2F, 8'hFF);
    @(posedge clk);
    axi_read(port_mux_pkg::OFF_ANALOG_SELECT, 32'h2F, port_mux_pkg::RESP_OKAY);
    axi_read(port_mux_pkg::OFF_SLEW_RATE, 32'h1F, port_mux_pkg::RESP_OKAY);
    axi_read(port_mux_pkg::OFF_DIRECTION, 32'hFF, port_mux_pkg::RESP_OKAY);
    axi_read(port_mux_pkg::OFF_OSC_CONFIG, 32'h18, port_mux_pkg::RESP_OKAY);
    axi_read(8'h40, 32'h0, port_mux_pkg::RESP_SLVERR);
    axi_write(port_mux_pkg::OFF_PIN_STATUS, 8'h00, port_mux_pkg::RESP_SLVERR);
    axi_write(port_mux_pkg::OFF_ANALOG_SELECT, 8'hFF, port_mux_pkg::RESP_OKAY);
    axi_read(port_mux_pkg::OFF_ANALOG_SELECT, 32'h2F, port_mux_pkg::RESP_OKAY);
    for (int i = 0; i < 48; i++) begin
      rnd = $random(seed);
      cmd <= rnd[9:0];
      pin_in <= rnd[31:24];
      rnd = $random(seed);
      {ana_m, lat_m, dir_m} = rnd[23:0];
      osc_m = {3'h0, rnd[28:26], i[1:0]};
      axi_write(port_mux_pkg::OFF_DIRECTION, dir_m, port_mux_pkg::RESP_OKAY);
      axi_write(port_mux_pkg::OFF_PIN_LEVEL, lat_m, port_mux_pkg::RESP_OKAY);
      axi_write(port_mux_pkg::OFF_ANALOG_SELECT, ana_m, port_mux_pkg::RESP_OKAY);
      axi_write(port_mux_pkg::OFF_OSC_CONFIG, osc_m, port_mux_pkg::RESP_OKAY);
      repeat (3) @(posedge clk);
      @(negedge clk);
      e = expect_pins(periph);
      check(oe_n, e[15:8], 8'hFF);
      check(pin_out, e[7:0], e[23:16]);
      check(ana_en, ana_m & 8'h2F, 8'hFF);
      din_x = {pin_in[7] & (osc_m[1:0] == 2'h0), pin_in[6] & (osc_m[2:0] == 3'h0),
        pin_in[5:0] & ~(ana_m[5:0] & 6'h2F)};
      check(dig_in, din_x, 8'hFF);
      @(posedge clk);
      axi_read(port_mux_pkg::OFF_PIN_LEVEL, {24'h0, din_x}, port_mux_pkg::RESP_OKAY);
      axi_read(port_mux_pkg::OFF_PIN_STATUS, {24'h0, ~e[15:8]}, port_mux_pkg::RESP_OKAY);
    end
    wstrb <= 4'h0;
    axi_write(port_mux_pkg::OFF_DIRECTION, ~dir_m, port_mux_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(port_mux_pkg::OFF_DIRECTION, {24'h0, dir_m}, port_mux_pkg::RESP_OKAY);
    complete_run();
  end
endmodule : testbench
